// ---- design/atfd_pkg.sv ----
// Package for the threshold flag detector: register indexes, field positions,
// reset values and the carrier structs. Assumes 32-bit AXI4-Lite, one register per word.
package atfd_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 12;       // Byte address width of the slave.
  localparam int          IDX_W     = 10;       // Word index width.
  localparam logic [9:0]  IDX_CTRL  = 10'h245;  // Flag output control.
  localparam logic [9:0]  IDX_UPL   = 10'h247;  // Upper threshold, low byte.
  localparam logic [9:0]  IDX_UPH   = 10'h248;  // Upper threshold, high five bits.
  localparam logic [9:0]  IDX_LOL   = 10'h249;  // Lower threshold, low byte.
  localparam logic [9:0]  IDX_LOH   = 10'h24a;  // Lower threshold, high five bits.
  localparam logic [9:0]  IDX_DWL   = 10'h24b;  // Dwell target, low byte.
  localparam logic [9:0]  IDX_DWH   = 10'h24c;  // Dwell target, high byte.
  localparam logic [9:0]  IDX_STAT  = 10'h24d;  // Detector status, read only.

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int          CTRL_EN    = 0;   // Enable the flag output.
  localparam int          CTRL_LEVEL = 2;   // Level driven while forcing.
  localparam int          CTRL_FORCE = 3;   // Select the forced level.
  localparam logic [7:0]  CTRL_MASK  = 8'h0d; // Writable control bits.
  localparam int          THR_W      = 13;  // Threshold and magnitude width.
  localparam int          THR_HI_W   = 5;   // Bits held in a high threshold register.
  localparam int          DWELL_W    = 16;  // Dwell counter width.
  localparam int          STAT_FLAG  = 0;   // Status: detector flag.
  localparam int          STAT_PIN   = 1;   // Status: level on the pin.

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00; // Every register resets to zero.
  localparam logic [1:0]  RESP_OKAY  = 2'h0;  // Access accepted.
  localparam logic [1:0]  RESP_SLVERR = 2'h2; // Unmapped index.

  // Detector configuration, assembled from the registers.
  typedef struct packed {
    logic                 enable;
    logic [THR_W-1:0]     upper;
    logic [THR_W-1:0]     lower;
    logic [DWELL_W-1:0]   dwell;
  } atfd_cfg_t;

  // Detector state.
  typedef struct packed {
    logic                 flag;
    logic [DWELL_W-1:0]   cnt;
  } atfd_det_t;

endpackage : atfd_pkg

// ---- design/atfd_detector.sv ----
// Threshold detector core: raises a flag above the upper threshold and drops it
// after the magnitude dwells below the lower threshold. Same clock as the samples.
module atfd_detector (
  input  wire logic               clk_i,        // Core clock.
  input  wire logic               rstn_i,       // Asynchronous reset, active low.
  input  wire atfd_pkg::atfd_cfg_t cfg_i,       // Live configuration.
  input  wire logic               valid_i,      // Sample strobe.
  input  wire logic [12:0]        mag_i,        // Fine magnitude of the sample.
  output logic                    flag_o,       // Detector flag.
  output logic [15:0]             cnt_o         // Dwell counter; not read by the top or its status register.
);
  import atfd_pkg::*;

  atfd_det_t st_r;   // Whole state of the detector.
  atfd_det_t st_nxt; // Its next value.

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The counter holds the target while the magnitude is not low and counts
  // down while it is; a target of N clears after N+1 low samples.
  always_comb begin
    st_nxt = st_r;
    if (!cfg_i.enable) begin
      st_nxt.flag = 1'b0;
      st_nxt.cnt  = cfg_i.dwell;
    end else if (valid_i) begin
      if (mag_i > cfg_i.upper) begin
        st_nxt.flag = 1'b1;
        st_nxt.cnt  = cfg_i.dwell;
      end else if (mag_i < cfg_i.lower) begin
        if (st_r.cnt == '0) begin
          st_nxt.flag = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end else begin
        st_nxt.cnt = cfg_i.dwell;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;
  assign cnt_o  = st_r.cnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_low_wait;
    cfg_i.enable && valid_i && st_r.flag && mag_i < cfg_i.lower && mag_i <= cfg_i.upper && st_r.cnt != '0;
  endsequence
  property p_dwell_hold;
    s_low_wait |=> st_r.flag && st_r.cnt == $past(st_r.cnt) - 16'h0001;
  endproperty
  a_dwell_hold: assert property (p_dwell_hold) else $error("flag left before dwell ran out");
  property p_dwell_clear;
    cfg_i.enable && valid_i && mag_i < cfg_i.lower && mag_i <= cfg_i.upper && st_r.cnt == '0 |=> !st_r.flag;
  endproperty
  a_dwell_clear: assert property (p_dwell_clear) else $error("flag not cleared at dwell end");
  property p_between;
    cfg_i.enable && valid_i && st_r.flag && mag_i >= cfg_i.lower && mag_i <= cfg_i.upper
      |=> st_r.flag && st_r.cnt == $past(cfg_i.dwell);
  endproperty
  a_between: assert property (p_between) else $error("in-band sample disturbed flag");
endmodule // atfd_detector

// ---- design/adc_threshold_fast_detect.sv ----
// Top of the threshold flag block: AXI4-Lite register slave, flag force and
// enable logic, and the detector. Samples come from logic on the same clock.
//
// Contract
// - Force bit 3 selects forced pin level.
// - While forcing, pin equals force-level bit 2.
// - Enable bit 0 gates the flag output.
// - Compare magnitude against 13-bit upper threshold.
// - Upper threshold is high[4:0] and low[7:0].
// - Compare magnitude against 13-bit lower threshold.
// - Lower threshold is high[4:0] and low[7:0].
// - Dwell counter times low run before clearing.
// - Dwell target high byte sits next register.
//
// Added by the designer: the AXI4-Lite register port.
module adc_threshold_fast_detect (
  input  wire logic                     CORE_CLK_I,        // Core clock, 25 MHz.
  input  wire logic                     RSTN_I,            // Asynchronous reset, active low.
  input  wire logic [atfd_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write address.
  input  wire logic                     S_AXI_AWVALID_I,   // Write address valid.
  output logic                          S_AXI_AWREADY_O,   // Write address ready.
  input  wire logic [31:0]              S_AXI_WDATA_I,     // Write data.
  input  wire logic [3:0]               S_AXI_WSTRB_I,     // Write strobes.
  input  wire logic                     S_AXI_WVALID_I,    // Write data valid.
  output logic                          S_AXI_WREADY_O,    // Write data ready.
  output logic [1:0]                    S_AXI_BRESP_O,     // Write response.
  output logic                          S_AXI_BVALID_O,    // Write response valid.
  input  wire logic                     S_AXI_BREADY_I,    // Write response ready.
  input  wire logic [atfd_pkg::ADDR_W-1:0] S_AXI_ARADDR_I, // Read address.
  input  wire logic                     S_AXI_ARVALID_I,   // Read address valid.
  output logic                          S_AXI_ARREADY_O,   // Read address ready.
  output logic [31:0]                   S_AXI_RDATA_O,     // Read data.
  output logic [1:0]                    S_AXI_RRESP_O,     // Read response.
  output logic                          S_AXI_RVALID_O,    // Read data valid.
  input  wire logic                     S_AXI_RREADY_I,    // Read data ready.
  input  wire logic                     SAMPLE_VALID_I,    // Sample strobe, core clock.
  input  wire logic [12:0]              FINE_MAGNITUDE_I,  // Fine magnitude of the sample.
  output logic                          PER_CHANNEL_THRESHOLD_FLAG_PIN_O // Flag pin.
);
  import atfd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All state lives in one struct so the bus side and the pin share one
  // register process and one reset.
  typedef struct packed {
    logic [7:0]       ctrl;     // Flag output control.
    logic [7:0]       upl;      // Upper threshold low byte.
    logic [4:0]       uph;      // Upper threshold high bits.
    logic [7:0]       lol;      // Lower threshold low byte.
    logic [4:0]       loh;      // Lower threshold high bits.
    logic [7:0]       dwl;      // Dwell target low byte.
    logic [7:0]       dwh;      // Dwell target high byte.
    logic             aw_held;  // Write address captured.
    logic [IDX_W-1:0] aw_idx;   // Captured write index.
    logic             w_held;   // Write data captured.
    logic [7:0]       wdata;    // Captured write byte.
    logic             wstrb0;   // Captured strobe of byte lane 0.
    logic             awready;  // Write address ready.
    logic             wready;   // Write data ready.
    logic             bvalid;   // Write response pending.
    logic [1:0]       bresp;    // Write response code.
    logic             arready;  // Read address ready.
    logic             rvalid;   // Read data pending.
    logic [7:0]       rdata;    // Read byte.
    logic [1:0]       rresp;    // Read response code.
    logic             pin;      // Flag pin level.
  } atfd_top_t;

  atfd_top_t  st_r;      // Registered state.
  atfd_top_t  st_nxt;    // Next state.
  atfd_cfg_t  cfg;       // Detector configuration.
  logic       det_flag;  // Detector flag.
  logic [15:0] det_cnt;  // Dwell counter.
  logic       wr_do;     // A complete write is applied this cycle.
  logic [12:0] upper_thr; // Assembled upper threshold.
  logic [12:0] lower_thr; // Assembled lower threshold.

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // True for every index that the slave answers with OKAY.
  function automatic logic reg_hit(input logic [IDX_W-1:0] idx);
    reg_hit = (idx == IDX_CTRL) || (idx == IDX_UPL) || (idx == IDX_UPH) ||
              (idx == IDX_LOL) || (idx == IDX_LOH) || (idx == IDX_DWL) ||
              (idx == IDX_DWH) || (idx == IDX_STAT);
  endfunction

  // Read value of a register; reserved bits read as zero.
  function automatic logic [7:0] reg_read(input atfd_top_t s, input logic [IDX_W-1:0] idx,
                                          input logic flag);
    unique case (idx)
      IDX_CTRL: reg_read = s.ctrl & CTRL_MASK;
      IDX_UPL:  reg_read = s.upl;
      IDX_UPH:  reg_read = {3'h0, s.uph};
      IDX_LOL:  reg_read = s.lol;
      IDX_LOH:  reg_read = {3'h0, s.loh};
      IDX_DWL:  reg_read = s.dwl;
      IDX_DWH:  reg_read = s.dwh;
      IDX_STAT: reg_read = {6'h00, s.pin, flag};
      default:  reg_read = RST_BYTE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Configuration assembly
  // ----------------------------------------------------------------
  assign upper_thr = {st_r.uph, st_r.upl};
  assign lower_thr = {st_r.loh, st_r.lol};
  // One assignment fills the whole struct, so the configuration has a single driver.
  assign cfg = '{enable : st_r.ctrl[CTRL_EN],
                 upper  : upper_thr,
                 lower  : lower_thr,
                 dwell  : {st_r.dwh, st_r.dwl}};

  // A write is applied once address and data are both held and the
  // previous response has gone; this keeps one write in flight.
  assign wr_do = st_r.aw_held && st_r.w_held && !st_r.bvalid;

  // ----------------------------------------------------------------
  // Detector
  // ----------------------------------------------------------------
  atfd_detector u_det (
    .clk_i   (CORE_CLK_I),
    .rstn_i  (RSTN_I),
    .cfg_i   (cfg),
    .valid_i (SAMPLE_VALID_I),
    .mag_i   (FINE_MAGNITUDE_I),
    .flag_o  (det_flag),
    .cnt_o   (det_cnt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Capture the write address when offered and free.
    if (S_AXI_AWVALID_I && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_idx  = S_AXI_AWADDR_I[ADDR_W-1:2];
    end
    // Capture the write data independently of the address.
    if (S_AXI_WVALID_I && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = S_AXI_WDATA_I[7:0];
      st_nxt.wstrb0 = S_AXI_WSTRB_I[0];
    end
    // The response leaves when the master takes it.
    if (st_r.bvalid && S_AXI_BREADY_I) begin
      st_nxt.bvalid = 1'b0;
    end
    // Apply the write; only byte lane 0 carries register data.
    if (wr_do) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = reg_hit(st_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.wstrb0) begin
        unique case (st_r.aw_idx)
          IDX_CTRL: st_nxt.ctrl = st_r.wdata & CTRL_MASK;
          IDX_UPL:  st_nxt.upl  = st_r.wdata;
          IDX_UPH:  st_nxt.uph  = st_r.wdata[THR_HI_W-1:0];
          IDX_LOL:  st_nxt.lol  = st_r.wdata;
          IDX_LOH:  st_nxt.loh  = st_r.wdata[THR_HI_W-1:0];
          IDX_DWL:  st_nxt.dwl  = st_r.wdata;
          IDX_DWH:  st_nxt.dwh  = st_r.wdata;
          default:  st_nxt.ctrl = st_r.ctrl;
        endcase
      end
    end
    // Ready is offered only when nothing of that channel is held, so
    // a second write waits for the first response to be taken.
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;
    // Read data leaves when the master takes it.
    if (st_r.rvalid && S_AXI_RREADY_I) begin
      st_nxt.rvalid = 1'b0;
    end
    // Take a read and answer it on the next cycle.
    if (S_AXI_ARVALID_I && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = reg_read(st_r, S_AXI_ARADDR_I[ADDR_W-1:2], det_flag);
      st_nxt.rresp  = reg_hit(S_AXI_ARADDR_I[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;
    // Forcing overrides detection; otherwise the enable gates the flag.
    if (st_r.ctrl[CTRL_FORCE]) begin
      st_nxt.pin = st_r.ctrl[CTRL_LEVEL];
    end else begin
      st_nxt.pin = st_r.ctrl[CTRL_EN] && det_flag;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Ready lines stay low during reset and rise at the first edge after.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a register field; the read data is
  // zero-extended because only byte lane 0 carries register data.
  assign S_AXI_AWREADY_O = st_r.awready;
  assign S_AXI_WREADY_O  = st_r.wready;
  assign S_AXI_BVALID_O  = st_r.bvalid;
  assign S_AXI_BRESP_O   = st_r.bresp;
  assign S_AXI_ARREADY_O = st_r.arready;
  assign S_AXI_RVALID_O  = st_r.rvalid;
  assign S_AXI_RRESP_O   = st_r.rresp;
  assign S_AXI_RDATA_O   = {24'h000000, st_r.rdata};
  assign PER_CHANNEL_THRESHOLD_FLAG_PIN_O = st_r.pin;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // The checks sleep during reset: the ready lines are held low there on
  // purpose and would otherwise trip the bus properties.

  // A sample above the upper threshold while enabled and not forced.
  sequence s_over;
    st_r.ctrl[CTRL_EN] && !st_r.ctrl[CTRL_FORCE] && SAMPLE_VALID_I && FINE_MAGNITUDE_I > upper_thr;
  endsequence
  // Enable and normal selection held over the two-stage path to the pin.
  sequence s_normal2;
    (st_r.ctrl[CTRL_EN] && !st_r.ctrl[CTRL_FORCE]) [*2];
  endsequence

  property p_force_sel;
    st_r.ctrl[CTRL_FORCE] |=> PER_CHANNEL_THRESHOLD_FLAG_PIN_O == $past(st_r.ctrl[CTRL_LEVEL]);
  endproperty
  a_force_sel: assert property (p_force_sel) else $error("forced pin not at force level");

  property p_force_hold;
    st_r.ctrl[CTRL_FORCE] [*2] |=> $stable(PER_CHANNEL_THRESHOLD_FLAG_PIN_O) || $changed($past(st_r.ctrl));
  endproperty
  a_force_hold: assert property (p_force_hold) else $error("forced pin moved");

  property p_disabled;
    !st_r.ctrl[CTRL_EN] && !st_r.ctrl[CTRL_FORCE] |=> !PER_CHANNEL_THRESHOLD_FLAG_PIN_O;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin high");

  property p_over_sets;
    s_over ##0 s_normal2 |=> ##1 PER_CHANNEL_THRESHOLD_FLAG_PIN_O;
  endproperty
  a_over_sets: assert property (p_over_sets) else $error("pin not set after over-threshold");

  property p_upper_hi;
    wr_do && st_r.wstrb0 && st_r.aw_idx == IDX_UPH
      |=> upper_thr[12:8] == $past(st_r.wdata[4:0]) && upper_thr[7:0] == $past(st_r.upl);
  endproperty
  a_upper_hi: assert property (p_upper_hi) else $error("upper threshold high bits wrong");

  property p_lower_hi;
    wr_do && st_r.wstrb0 && st_r.aw_idx == IDX_LOH
      |=> lower_thr[12:8] == $past(st_r.wdata[4:0]) && lower_thr[7:0] == $past(st_r.lol);
  endproperty
  a_lower_hi: assert property (p_lower_hi) else $error("lower threshold high bits wrong");

  property p_dwell_hi;
    wr_do && st_r.wstrb0 && st_r.aw_idx == IDX_DWH |=> cfg.dwell[15:8] == $past(st_r.wdata);
  endproperty
  a_dwell_hi: assert property (p_dwell_hi) else $error("dwell high byte wrong");

  property p_hold_flag;
    det_flag && st_r.ctrl[CTRL_EN] && (!SAMPLE_VALID_I || FINE_MAGNITUDE_I >= lower_thr) |=> det_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("flag dropped without low sample");

  property p_bus_resp;
    wr_do |=> S_AXI_BVALID_O && S_AXI_BRESP_O == (reg_hit($past(st_r.aw_idx)) ? RESP_OKAY : RESP_SLVERR);
  endproperty
  a_bus_resp: assert property (p_bus_resp) else $error("write response missing or wrong");

  // While enabled and not forcing, the pin copies the detector flag one edge later, so the
  // gain loop sees a set flag for as long as the detector holds it.
  property p_pin_follow;
    st_r.ctrl[CTRL_EN] && !st_r.ctrl[CTRL_FORCE] |=> PER_CHANNEL_THRESHOLD_FLAG_PIN_O == $past(det_flag);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow detector flag");

  // A pending write response blocks both write channels; this is what keeps
  // a second write from landing before the first answer has been taken.
  property p_write_block;
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  a_write_block: assert property (p_write_block) else $error("write channel open while response pending");

  // A taken read is answered at the next edge and closes the address channel.
  property p_read_answer;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule // adc_threshold_fast_detect

// ---- tb/atfd_agc_model.sv ----
// Far-side model: the gain-control logic that watches the flag pin.
// Assumes the pin is a registered level on the core clock.
module atfd_agc_model (
  input  wire logic CLK_I,   // Core clock.
  input  wire logic RSTN_I,  // Reset, active low.
  input  wire logic PIN_I,   // Flag pin from the block.
  output int        RISES_O  // Count of gain-step requests seen.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r;  // Pin level at the previous edge.
  // Only rises count: each one asks the gain loop to step down once.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      last_r  <= 1'b0;
      RISES_O <= 0;
    end else begin
      last_r <= PIN_I;
      if (PIN_I && !last_r) begin
        RISES_O <= RISES_O + 1;
      end
    end
  end
endmodule // atfd_agc_model

// ---- tb/tb_adc_threshold_fast_detect.sv ----
// Testbench: register access over AXI4-Lite, sample stream, pin checks.
// Assumes the slave and the sample input share one 25 MHz clock.
module tb_adc_threshold_fast_detect;
  timeunit 1ns;
  timeprecision 1ps;
  import atfd_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, sv = 0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [3:0] ws = 4'h1;
  logic [12:0] mag = '0;
  logic awr, wr, bv, arr, rv, pin;
  logic [1:0] br, rr;
  int num_errors = 0, checked = 0, cyc = 0, rises;
  // Register list, reset-then-mask readback values.
  logic [9:0] ix[7] = '{IDX_CTRL, IDX_UPL, IDX_UPH, IDX_LOL, IDX_LOH, IDX_DWL, IDX_DWH};
  logic [7:0] mk[7] = '{CTRL_MASK, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'hff};
  // Upper 0x200, lower 0x105, dwell 0x0101, then enable.
  logic [7:0] pv[8] = '{8'h00, 8'h00, 8'h02, 8'h05, 8'h01, 8'h01, 8'h01, 8'h01};

  adc_threshold_fast_detect dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy), .SAMPLE_VALID_I(sv),
    .FINE_MAGNITUDE_I(mag), .PER_CHANNEL_THRESHOLD_FLAG_PIN_O(pin));
  atfd_agc_model agc (.CLK_I(clk), .RSTN_I(rstn), .PIN_I(pin), .RISES_O(rises));

  // ----------------------------------------------------------------
  // Clock, watchdog and closing report
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  // About 700 cycles are needed; the ceiling leaves ample margin for a slow slave.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus tasks: address and data offered together, each dropped once taken.
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    brdy <= 1;
    while (!(a && w)) begin
      @(posedge clk);
      if (awv && awr) begin a = 1; awv <= 0; end
      if (wv && wr) begin w = 1; wv <= 0; end
    end
    while (!bv) @(posedge clk);
    brdy <= 0;
    chk("write response", {30'h0, er}, {30'h0, br});
  endtask
  task automatic rd_reg(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1;
    rrdy <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    while (!rv) @(posedge clk);
    rrdy <= 0;
    chk("read data", {24'h0, e}, rd);
    chk("read response", {30'h0, er}, {30'h0, rr});
  endtask
  // One sample, then the pin is looked at once it has had time to follow.
  task automatic smp(input logic [12:0] m);
    @(posedge clk);
    sv <= 1;
    mag <= m;
    @(posedge clk);
    sv <= 0;
  endtask
  task automatic pchk(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("flag pin", {31'h0, e}, {31'h0, pin});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    foreach (ix[k]) rd_reg(ix[k], RST_BYTE, RESP_OKAY);
    // Reserved bits must read back as zero after writing all ones.
    foreach (ix[k]) begin
      wr_reg(ix[k], 8'hff, RESP_OKAY);
      rd_reg(ix[k], mk[k], RESP_OKAY);
    end
    rd_reg(10'h246, 8'h00, RESP_SLVERR);
    wr_reg(10'h246, 8'h5a, RESP_SLVERR);
    ws <= 4'h0;
    wr_reg(IDX_UPL, 8'h12, RESP_OKAY);
    rd_reg(IDX_UPL, 8'hff, RESP_OKAY);
    ws <= 4'h1;
    wr_reg(IDX_CTRL, pv[0], RESP_OKAY);
    foreach (ix[k]) if (k > 0) wr_reg(ix[k], pv[k], RESP_OKAY);
    wr_reg(IDX_CTRL, pv[7], RESP_OKAY);
    // Detection: equal to upper is in band, one above sets the pin.
    smp(13'h200);
    pchk(1'b0);
    smp(13'h201);
    pchk(1'b1);
    smp(13'h105);
    // Equal to lower reloads the count; a target of 0x101 needs 0x102 below samples.
    repeat (257) smp(13'h104);
    pchk(1'b1);
    smp(13'h104);
    pchk(1'b0);
    wr_reg(IDX_CTRL, 8'h00, RESP_OKAY);
    smp(13'h1fff);
    pchk(1'b0);
    wr_reg(IDX_CTRL, 8'h0c, RESP_OKAY);
    pchk(1'b1);
    wr_reg(IDX_CTRL, 8'h09, RESP_OKAY);
    smp(13'h1fff);
    pchk(1'b0);
    // Status: detector flag set underneath, pin forced low.
    rd_reg(IDX_STAT, 8'h01, RESP_OKAY);
    wr_reg(IDX_CTRL, 8'h01, RESP_OKAY);
    pchk(1'b1);
    // Status is read only: a write is answered but leaves flag and pin bits set.
    wr_reg(IDX_STAT, 8'h00, RESP_OKAY);
    rd_reg(IDX_STAT, 8'h03, RESP_OKAY);
    // Rises: all-ones control, first detection, forced high, release of force.
    chk("pin rises", 32'd4, rises);
    complete_run();
  end
endmodule // tb_adc_threshold_fast_detect
